/* File: rtl/mplm_pkg.sv */
package mplm_pkg;

  // mode strap codes
  localparam logic [3:0] MPLM_MODE_INTERNAL = 4'h0;
  localparam logic [3:0] MPLM_MODE_EXT_CRYSTAL = 4'h1;
  localparam logic [3:0] MPLM_MODE_EXT_OSC = 4'h2;

  // operating setting: zero follows auto-negotiation, else manual bits
  localparam logic [2:0] MPLM_SETTING_AUTO = 3'h0;
  localparam int MPLM_SETTING_FDX_BIT = 0;
  localparam int MPLM_SETTING_SPD_BIT = 1;

  // activity indicator hold time
  localparam int MPLM_SYS_CLK_HZ = 125000000;
  localparam int MPLM_ACT_PULSE_MS = 40;
  localparam int MPLM_ACT_PULSE_CYCLES = MPLM_ACT_PULSE_MS * (MPLM_SYS_CLK_HZ / 1000);
  localparam int MPLM_ACT_CNT_W = 23;

  // inactive level of every active-low indicator
  localparam logic MPLM_LED_OFF = 1'b1;

  typedef enum logic [2:0] {
    MPLM_TX_IDLE = 3'b001,
    MPLM_TX_LOW = 3'b010,
    MPLM_TX_HIGH = 3'b100
  } mplm_tx_fsm_type;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } mplm_tx_byte_type;

  typedef struct packed {
    logic [3:0] strap_s1;
    logic [3:0] strap_s2;
    logic strap_taken;
    logic ext_mode;
    logic crs_s1;
    logic crs_s2;
    logic col_s1;
    logic col_s2;
    logic fdx_s1;
    logic fdx_s2;
    logic full_duplex;
    logic speed_100;
    logic carrier;
    logic collision;
    mplm_tx_byte_type tx_hold;
    logic tx_busy;
    logic tx_ready;
    logic tx_req_tgl;
    logic ack_s1;
    logic ack_s2;
    logic ack_s3;
    logic byte_s1;
    logic byte_s2;
    logic byte_s3;
    logic end_s1;
    logic end_s2;
    logic end_s3;
    logic rx_valid;
    logic rx_end;
    logic rx_odd;
    logic [7:0] rx_data;
    logic col_led_n;
    logic fdx_led_n;
    logic spd_led_n;
    logic link_led_n;
  } mplm_sys_state_type;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic ext_s1;
    logic ext_s2;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic ack_tgl;
    logic pend;
    mplm_tx_byte_type pend_byte;
    mplm_tx_byte_type shift;
    mplm_tx_fsm_type fsm;
    logic tx_en;
    logic [3:0] txd;
  } mplm_tx_state_type;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic dv_prev;
    logic have_lo;
    logic [3:0] lo;
    logic [7:0] data;
    logic byte_tgl;
    logic end_tgl;
    logic odd;
  } mplm_rx_state_type;

  typedef struct packed {
    logic [MPLM_ACT_CNT_W-1:0] cnt;
    logic out_n;
  } mplm_stretch_state_type;

endpackage : mplm_pkg

/* File: rtl/mplm_port.sv */
// Overview of operation
// - shared pins carry MII toward external PHY only for strap 0001 or 0010
// - strap 0000 turns the shared pins into network indicator outputs
// - transmit data leaves as nibbles on tx clock, bit 3 most significant
// - collision input is asynchronous; acted on in half duplex only
// - while receive valid, nibbles on rx clock captured, bit 3 most significant
// - PHY frames receive valid; device samples it on rising rx clock
// - duplex select input active low: 0 full duplex, 1 half duplex
// - dedicated active-low link indicator shows media link up
// - internal mode: active-low tx activity indicator pulses during transmit
// - internal mode: active-low rx activity indicator pulses during receive
// - active-low collision indicator on half-duplex collisions, never in full duplex
// - duplex indicator low for full, high for half, auto or manual
// - speed indicator low at 100Mbps, high at 10Mbps, auto or manual
// - strap 0001 external PHY with crystal, 0010 external PHY with oscillator
`timescale 1ns/1ps

module mplm_stretch #(
  parameter int unsigned HOLD_CYCLES = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic active,
  output logic indicator_n
);

  mplm_pkg::mplm_stretch_state_type state_q;
  mplm_pkg::mplm_stretch_state_type state_d;

  // holds the indicator low long enough for a human eye to notice short bursts
  always_comb begin
    state_d = state_q;
    if (active) begin
      state_d.cnt = mplm_pkg::MPLM_ACT_CNT_W'(HOLD_CYCLES - 1);
      state_d.out_n = 1'b0;
    end else if (state_q.cnt != '0) begin
      state_d.cnt = state_q.cnt - 1'b1;
      state_d.out_n = 1'b0;
    end else begin
      state_d.out_n = mplm_pkg::MPLM_LED_OFF;
    end
    if (reset) begin
      state_d.cnt = '0;
      state_d.out_n = mplm_pkg::MPLM_LED_OFF;
    end
  end

  always_ff @(posedge clk) begin
    state_q <= state_d;
  end

  assign indicator_n = state_q.out_n;

endmodule : mplm_stretch

module mplm_port #(
  parameter int unsigned ACT_PULSE_CYCLES = mplm_pkg::MPLM_ACT_PULSE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] mode_strap,
  // core transmit byte stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  // core receive byte stream
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic rx_odd_nibble,
  // core status
  output logic ext_phy_mode,
  output logic carrier_sense,
  output logic collision_detected,
  output logic full_duplex,
  // MII toward the external PHY
  input wire logic mii_tx_clk,
  output logic mii_tx_en,
  output logic [3:0] mii_txd,
  input wire logic mii_rx_clk,
  input wire logic mii_rx_dv,
  input wire logic [3:0] mii_rxd,
  input wire logic mii_crs,
  input wire logic mii_col,
  input wire logic duplex_select_n,
  // internal PHY status
  input wire logic int_tx_activity,
  input wire logic int_rx_activity,
  input wire logic int_collision,
  input wire logic link_up,
  input wire logic autoneg_full_duplex,
  input wire logic autoneg_speed_100,
  input wire logic [2:0] operating_setting,
  // indicators
  output logic tx_activity_indicator_n,
  output logic rx_activity_indicator_n,
  output logic collision_indicator_n,
  output logic duplex_indicator_n,
  output logic speed_indicator_n,
  output logic link_up_indicator_n
);

  mplm_pkg::mplm_sys_state_type sys_q;
  mplm_pkg::mplm_sys_state_type sys_d;
  mplm_pkg::mplm_tx_state_type tx_q;
  mplm_pkg::mplm_tx_state_type tx_d;
  mplm_pkg::mplm_rx_state_type rx_q;
  mplm_pkg::mplm_rx_state_type rx_d;

  // core clock domain
  always_comb begin
    sys_d = sys_q;
    sys_d.strap_s1 = mode_strap;
    sys_d.strap_s2 = sys_q.strap_s1;
    sys_d.crs_s1 = mii_crs;
    sys_d.crs_s2 = sys_q.crs_s1;
    sys_d.col_s1 = mii_col;
    sys_d.col_s2 = sys_q.col_s1;
    sys_d.fdx_s1 = duplex_select_n;
    sys_d.fdx_s2 = sys_q.fdx_s1;
    sys_d.ack_s1 = tx_q.ack_tgl;
    sys_d.ack_s2 = sys_q.ack_s1;
    sys_d.ack_s3 = sys_q.ack_s2;
    sys_d.byte_s1 = rx_q.byte_tgl;
    sys_d.byte_s2 = sys_q.byte_s1;
    sys_d.byte_s3 = sys_q.byte_s2;
    sys_d.end_s1 = rx_q.end_tgl;
    sys_d.end_s2 = sys_q.end_s1;
    sys_d.end_s3 = sys_q.end_s2;

    // strap is caught once, on the first edge after reset release
    if (!sys_q.strap_taken) begin
      sys_d.strap_taken = 1'b1;
      sys_d.ext_mode = (sys_q.strap_s2 == mplm_pkg::MPLM_MODE_EXT_CRYSTAL) ||
                       (sys_q.strap_s2 == mplm_pkg::MPLM_MODE_EXT_OSC);
    end

    // duplex and speed
    if (sys_q.ext_mode) begin
      sys_d.full_duplex = !sys_q.fdx_s2;
    end else if (operating_setting == mplm_pkg::MPLM_SETTING_AUTO) begin
      sys_d.full_duplex = autoneg_full_duplex;
    end else begin
      sys_d.full_duplex = operating_setting[mplm_pkg::MPLM_SETTING_FDX_BIT];
    end
    if (operating_setting == mplm_pkg::MPLM_SETTING_AUTO) begin
      sys_d.speed_100 = autoneg_speed_100;
    end else begin
      sys_d.speed_100 = operating_setting[mplm_pkg::MPLM_SETTING_SPD_BIT];
    end

    sys_d.carrier = sys_q.ext_mode && sys_q.crs_s2;
    // a collision report in full duplex is spurious, so it is dropped here
    if (sys_q.full_duplex) begin
      sys_d.collision = 1'b0;
    end else if (sys_q.ext_mode) begin
      sys_d.collision = sys_q.col_s2;
    end else begin
      sys_d.collision = int_collision;
    end

    // shared-pin indicators only light in internal mode, as the pins belong to MII otherwise; the link indicator follows link_up in both
    sys_d.col_led_n = !(!sys_q.ext_mode && sys_q.collision);
    sys_d.fdx_led_n = !(!sys_q.ext_mode && sys_q.full_duplex);
    sys_d.spd_led_n = !(!sys_q.ext_mode && sys_q.speed_100);
    sys_d.link_led_n = !link_up;

    // transmit byte handshake toward the tx clock domain
    if (sys_q.tx_busy && (sys_q.ack_s2 != sys_q.ack_s3)) begin
      sys_d.tx_busy = 1'b0;
    end
    if (tx_valid && sys_q.tx_ready) begin
      sys_d.tx_hold.data = tx_data;
      sys_d.tx_hold.last = tx_last;
      sys_d.tx_req_tgl = !sys_q.tx_req_tgl;
      sys_d.tx_busy = 1'b1;
    end
    sys_d.tx_ready = sys_q.ext_mode && !sys_d.tx_busy;

    // receive bytes; held data is stable for two rx clocks after its toggle
    sys_d.rx_valid = sys_q.ext_mode && (sys_q.byte_s2 != sys_q.byte_s3);
    if (sys_d.rx_valid) begin
      sys_d.rx_data = rx_q.data;
    end
    sys_d.rx_end = sys_q.ext_mode && (sys_q.end_s2 != sys_q.end_s3);
    if (sys_d.rx_end) begin
      sys_d.rx_odd = rx_q.odd;
    end

    if (reset) begin
      sys_d = '0;
      sys_d.strap_s1 = mode_strap;
      sys_d.strap_s2 = sys_q.strap_s1;
      sys_d.col_led_n = mplm_pkg::MPLM_LED_OFF;
      sys_d.fdx_led_n = mplm_pkg::MPLM_LED_OFF;
      sys_d.spd_led_n = mplm_pkg::MPLM_LED_OFF;
      sys_d.link_led_n = mplm_pkg::MPLM_LED_OFF;
    end
  end

  always_ff @(posedge sys_clk) begin
    sys_q <= sys_d;
  end

  // transmit clock domain, also the network clock
  always_comb begin
    tx_d = tx_q;
    tx_d.rst_s1 = reset;
    tx_d.rst_s2 = tx_q.rst_s1;
    tx_d.ext_s1 = sys_q.ext_mode;
    tx_d.ext_s2 = tx_q.ext_s1;
    tx_d.req_s1 = sys_q.tx_req_tgl;
    tx_d.req_s2 = tx_q.req_s1;
    tx_d.req_s3 = tx_q.req_s2;

    case (tx_q.fsm)
      mplm_pkg::MPLM_TX_IDLE: begin
        tx_d.tx_en = 1'b0;
        tx_d.txd = 4'h0;
        if (tx_q.pend && tx_q.ext_s2) begin
          tx_d.shift = tx_q.pend_byte;
          tx_d.pend = 1'b0;
          tx_d.tx_en = 1'b1;
          tx_d.txd = tx_q.pend_byte.data[3:0];
          tx_d.fsm = mplm_pkg::MPLM_TX_LOW;
        end
      end
      mplm_pkg::MPLM_TX_LOW: begin
        tx_d.txd = tx_q.shift.data[7:4];
        tx_d.fsm = mplm_pkg::MPLM_TX_HIGH;
      end
      mplm_pkg::MPLM_TX_HIGH: begin
        if (!tx_q.shift.last && tx_q.pend) begin
          tx_d.shift = tx_q.pend_byte;
          tx_d.pend = 1'b0;
          tx_d.txd = tx_q.pend_byte.data[3:0];
          tx_d.fsm = mplm_pkg::MPLM_TX_LOW;
        end else begin
          // last nibble done, or the core fell behind: the frame ends here
          tx_d.tx_en = 1'b0;
          tx_d.txd = 4'h0;
          tx_d.fsm = mplm_pkg::MPLM_TX_IDLE;
        end
      end
      default: begin
        tx_d.tx_en = 1'b0;
        tx_d.txd = 4'h0;
        tx_d.fsm = mplm_pkg::MPLM_TX_IDLE;
      end
    endcase

    // acking on capture keeps a second byte in flight, yet it reaches pend no sooner than MPLM_TX_HIGH ends the frame, so tx_en drops between bytes
    if (tx_q.req_s2 != tx_q.req_s3) begin
      tx_d.pend = 1'b1;
      tx_d.pend_byte = sys_q.tx_hold;
      tx_d.ack_tgl = !tx_q.ack_tgl;
    end

    if (tx_q.rst_s2) begin
      tx_d = '0;
      tx_d.rst_s1 = reset;
      tx_d.rst_s2 = tx_q.rst_s1;
      tx_d.fsm = mplm_pkg::MPLM_TX_IDLE;
    end
  end

  always_ff @(posedge mii_tx_clk) begin
    tx_q <= tx_d;
  end

  // receive clock domain
  always_comb begin
    rx_d = rx_q;
    rx_d.rst_s1 = reset;
    rx_d.rst_s2 = rx_q.rst_s1;
    rx_d.dv_prev = mii_rx_dv;
    if (mii_rx_dv) begin
      if (!rx_q.have_lo) begin
        rx_d.lo = mii_rxd;
        rx_d.have_lo = 1'b1;
      end else begin
        rx_d.data = {mii_rxd, rx_q.lo};
        rx_d.byte_tgl = !rx_q.byte_tgl;
        rx_d.have_lo = 1'b0;
      end
    end else if (rx_q.dv_prev) begin
      // end of frame; a lone trailing nibble is reported, not delivered
      rx_d.end_tgl = !rx_q.end_tgl;
      rx_d.odd = rx_q.have_lo;
      rx_d.have_lo = 1'b0;
    end
    if (rx_q.rst_s2) begin
      rx_d = '0;
      rx_d.rst_s1 = reset;
      rx_d.rst_s2 = rx_q.rst_s1;
    end
  end

  always_ff @(posedge mii_rx_clk) begin
    rx_q <= rx_d;
  end

  // activity indicators
  mplm_stretch #(
    .HOLD_CYCLES(ACT_PULSE_CYCLES)
  ) u_tx_act (
    .clk(sys_clk),
    .reset(reset),
    .active(int_tx_activity && !sys_q.ext_mode),
    .indicator_n(tx_activity_indicator_n)
  );

  mplm_stretch #(
    .HOLD_CYCLES(ACT_PULSE_CYCLES)
  ) u_rx_act (
    .clk(sys_clk),
    .reset(reset),
    .active(int_rx_activity && !sys_q.ext_mode),
    .indicator_n(rx_activity_indicator_n)
  );

  assign tx_ready = sys_q.tx_ready;
  assign rx_valid = sys_q.rx_valid;
  assign rx_data = sys_q.rx_data;
  assign rx_end = sys_q.rx_end;
  assign rx_odd_nibble = sys_q.rx_odd;
  assign ext_phy_mode = sys_q.ext_mode;
  assign carrier_sense = sys_q.carrier;
  assign collision_detected = sys_q.collision;
  assign full_duplex = sys_q.full_duplex;
  assign mii_tx_en = tx_q.tx_en;
  assign mii_txd = tx_q.txd;
  assign collision_indicator_n = sys_q.col_led_n;
  assign duplex_indicator_n = sys_q.fdx_led_n;
  assign speed_indicator_n = sys_q.spd_led_n;
  assign link_up_indicator_n = sys_q.link_led_n;

endmodule : mplm_port

/* File: tb/mplm_phy_model.sv */
`timescale 1ns/1ps
module mplm_phy_model (
  input wire logic mii_clk,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  output logic rx_dv,
  output logic [3:0] rxd
);
  logic [3:0] tx_q[$];
  initial begin
    rx_dv = 1'h0;
    rxd = 4'h5;
  end
  always @(posedge mii_clk) begin
    if (tx_en === 1'h1) tx_q.push_back(txd);
  end
  task automatic send(input logic [7:0] q[$], input bit odd);
    foreach (q[i]) begin
      for (int h = 0; h < 2; h++) begin
        @(negedge mii_clk);
        rx_dv <= 1'h1;
        rxd <= h ? q[i][7:4] : q[i][3:0];
      end
    end
    if (odd) begin
      @(negedge mii_clk);
      rxd <= ~rxd;
    end
    @(negedge mii_clk);
    rx_dv <= 1'h0;
    // no pull on the data lines, so show a changed value
    rxd <= ~rxd;
  endtask : send
endmodule : mplm_phy_model

/* File: tb/mplm_port_chk.sv */
`timescale 1ns/1ps
module mplm_port_chk (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic rx_end,
  input wire logic ext_phy_mode,
  input wire logic carrier_sense,
  input wire logic collision_detected,
  input wire logic full_duplex,
  input wire logic int_collision,
  input wire logic link_up,
  input wire logic [2:0] operating_setting,
  input wire logic collision_indicator_n,
  input wire logic duplex_indicator_n,
  input wire logic speed_indicator_n,
  input wire logic link_up_indicator_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_ext_held;
    ext_phy_mode [*3];
  endsequence
  sequence s_half_col;
    (!ext_phy_mode && int_collision && operating_setting == 3'h2) [*6];
  endsequence
  sequence s_full_col;
    (!ext_phy_mode && int_collision && operating_setting == 3'h1) [*6];
  endsequence
  a_ready_mode: assert property (!ext_phy_mode |-> !tx_ready) else $error("tx ready in led mode");
  a_take_ready: assert property (tx_valid && tx_ready |=> !tx_ready) else $error("ready after take");
  a_col_half: assert property (full_duplex [*5] |-> !collision_detected) else $error("full duplex col");
  a_ext_leds: assert property (s_ext_held |-> collision_indicator_n && duplex_indicator_n
    && speed_indicator_n) else $error("led low in mii mode");
  a_link_follow: assert property (1'h1 |=> link_up_indicator_n != $past(link_up))
    else $error("link indicator");
  a_rx_pulse: assert property (rx_valid |=> !rx_valid) else $error("rx valid stuck");
  a_rx_end: assert property (rx_end |=> !rx_end && !rx_valid) else $error("rx end stuck");
  a_no_carrier: assert property (!ext_phy_mode |-> !carrier_sense) else $error("carrier in led mode");
  a_half_leds: assert property (s_half_col |-> !collision_indicator_n && !speed_indicator_n
    && duplex_indicator_n) else $error("half duplex leds");
  a_full_leds: assert property (s_full_col |-> collision_indicator_n && speed_indicator_n
    && !duplex_indicator_n) else $error("full duplex leds");
endmodule : mplm_port_chk
bind mplm_port mplm_port_chk chk (.sys_clk, .reset, .tx_valid, .tx_ready, .rx_valid, .rx_end, .ext_phy_mode,
  .carrier_sense, .collision_detected, .full_duplex, .int_collision, .link_up, .operating_setting,
  .collision_indicator_n, .duplex_indicator_n, .speed_indicator_n, .link_up_indicator_n);

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam int ACT = 8;
  logic sys_clk, reset, mii_clk, tx_valid, tx_last, tx_ready, rx_valid, rx_end, rx_odd_nibble;
  logic ext_phy_mode, carrier_sense, collision_detected, full_duplex, mii_tx_en, mii_rx_dv, mii_crs, mii_col;
  logic duplex_select_n, int_tx_activity, int_rx_activity, int_collision, link_up;
  logic autoneg_full_duplex, autoneg_speed_100, tx_activity_indicator_n, rx_activity_indicator_n;
  logic collision_indicator_n, duplex_indicator_n, speed_indicator_n, link_up_indicator_n;
  logic [2:0] operating_setting;
  logic [3:0] mode_strap, mii_txd, mii_rxd;
  logic [7:0] tx_data, rx_data;
  logic [31:0] r = 32'hC6E0A1FF;
  logic [7:0] got_rx[$];
  logic [3:0] exp_tx[$];
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  mplm_port #(.ACT_PULSE_CYCLES(ACT)) uut (.sys_clk, .reset, .mode_strap, .tx_valid, .tx_data, .tx_last,
    .tx_ready, .rx_valid, .rx_data, .rx_end, .rx_odd_nibble, .ext_phy_mode, .carrier_sense,
    .collision_detected, .full_duplex, .mii_tx_clk(mii_clk), .mii_tx_en, .mii_txd, .mii_rx_clk(mii_clk),
    .mii_rx_dv, .mii_rxd, .mii_crs, .mii_col, .duplex_select_n, .int_tx_activity, .int_rx_activity,
    .int_collision, .link_up, .autoneg_full_duplex, .autoneg_speed_100, .operating_setting,
    .tx_activity_indicator_n, .rx_activity_indicator_n, .collision_indicator_n, .duplex_indicator_n,
    .speed_indicator_n, .link_up_indicator_n);
  mplm_phy_model phy (.mii_clk, .tx_en(mii_tx_en), .txd(mii_txd), .rx_dv(mii_rx_dv), .rxd(mii_rxd));
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    mii_clk = 1'h0;
    #37;
    forever #80 mii_clk = ~mii_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (rx_valid === 1'h1) got_rx.push_back(rx_data);
    if (cyc == 40000) begin
      fails++;
      summarize();
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic cw(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cw
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic summarize();
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic tx_frame(input int n);
    exp_tx.delete();
    phy.tx_q.delete();
    for (int i = 0; i < n; i++) begin
      r = nxt(r);
      tx_valid = 1'h1;
      tx_data = r[7:0];
      tx_last = (i == n - 1);
      exp_tx.push_back(r[3:0]);
      exp_tx.push_back(r[7:4]);
      while (tx_ready !== 1'h1) @(negedge sys_clk);
      @(negedge sys_clk);
    end
    tx_valid = 1'h0;
    // last byte needs a one-way sync plus three link clocks before its nibbles are out
    cw(160);
    chk("tx_nibbles", 8'(exp_tx.size()), 8'(phy.tx_q.size()));
    foreach (exp_tx[i]) chk("txd", 8'(exp_tx[i]), 8'(phy.tx_q[i]));
  endtask : tx_frame
  task automatic rx_frame(input int n, input bit odd);
    logic [7:0] q[$];
    got_rx.delete();
    for (int i = 0; i < n; i++) begin
      r = nxt(r);
      q.push_back(r[15:8]);
    end
    phy.send(q, odd);
    cw(40);
    chk("rx_count", 8'(n), 8'(got_rx.size()));
    foreach (q[i]) chk("rx_data", q[i], got_rx[i]);
    chk("rx_odd", 8'(odd), 8'(rx_odd_nibble));
  endtask : rx_frame
  task automatic status();
    for (int i = 0; i < 6; i++) begin
      r = nxt(r);
      mii_col = 1'h0;
      duplex_select_n = r[0];
      link_up = r[3];
      cw(8);
      mii_crs = r[1];
      mii_col = r[2];
      cw(8);
      chk("full_duplex", 8'(!r[0]), 8'(full_duplex));
      chk("carrier", 8'(r[1]), 8'(carrier_sense));
      chk("collision", 8'(r[2] & r[0]), 8'(collision_detected));
      chk("link_ind", 8'(!r[3]), 8'(link_up_indicator_n));
    end
    mii_col = 1'h0;
    mii_crs = 1'h0;
  endtask : status
  task automatic leds();
    logic fd;
    logic sp;
    for (int s = 0; s < 8; s++) begin
      r = nxt(r);
      int_collision = 1'h0;
      operating_setting = 3'(s);
      autoneg_full_duplex = r[0];
      autoneg_speed_100 = r[1];
      cw(8);
      int_collision = r[2] | (s != 0);
      cw(8);
      fd = (s == 0) ? r[0] : s[0];
      sp = (s == 0) ? r[1] : s[1];
      chk("duplex_ind", 8'(!fd), 8'(duplex_indicator_n));
      chk("speed_ind", 8'(!sp), 8'(speed_indicator_n));
      chk("col_ind", 8'(!(int_collision & !fd)), 8'(collision_indicator_n));
    end
    int_collision = 1'h0;
    for (int a = 1; a < 3; a++) begin
      int_tx_activity = a[0];
      int_rx_activity = a[1];
      cw(4);
      chk("act_on", 8'({!a[0], !a[1]}), 8'({tx_activity_indicator_n, rx_activity_indicator_n}));
      int_tx_activity = 1'h0;
      int_rx_activity = 1'h0;
      cw(ACT + 6);
      chk("act_off", 8'h03, 8'({tx_activity_indicator_n, rx_activity_indicator_n}));
    end
  endtask : leds
  initial begin
    logic [3:0] st[4];
    st = '{4'h1, 4'h2, 4'h0, 4'h5};
    {tx_valid, tx_last, tx_data, mii_crs, mii_col, int_tx_activity, int_rx_activity, int_collision} = '0;
    {link_up, autoneg_full_duplex, autoneg_speed_100, operating_setting} = '0;
    duplex_select_n = 1'h1;
    foreach (st[m]) begin
      reset = 1'h1;
      mode_strap = st[m];
      // held long enough for three link clock edges; shorter leaves the link domains unknown
      cw(64);
      reset = 1'h0;
      cw(64);
      chk("ext_mode", 8'(st[m] inside {4'h1, 4'h2}), 8'(ext_phy_mode));
      if (st[m] inside {4'h1, 4'h2}) begin
        tx_frame(1 + m * 2);
        rx_frame(3, m[0]);
        status();
      end else begin
        leds();
      end
    end
    summarize();
  end
endmodule : tb_top
